// File: src/i2cm_pkg.sv
// Constants, state encoding and shared types of the two-wire master sequencer.
//
// Contract
// R01 - Each instance has its own reload value.
// R02 - Reload counter runs on system clock.
// R03 - One clock period equals two rollovers.
// R04 - Counter pauses while released clock stays low.
// R05 - Clock seen high reloads counter, restarts.
// R06 - Start: count, then pull data low.
// R07 - Hold one rollover, clear start request.
// R08 - Lines low or clock low: collision.
// R09 - Buffer write during start: refused, flagged.
// R10 - Control writes ignored during start sequences.
// R11 - Restart request acts only when idle.
// R12 - Restart: clock low, short load, release.
// R13 - Restart: both high, then data low.
// R14 - Start seen early, event after timeout.
// R15 - Restart collision on data or clock low.
// R16 - Buffer write during restart: refused, flagged.
// R17 - Software loads address after restart event.
// R18 - Buffer write sets full, starts byte.
// R19 - Bits change on falling clock edges.
// R20 - Full cleared after eighth bit; data released.
// R21 - Ninth falling edge samples acknowledge result.
// R22 - After ninth clock: event, clock held low.
// R23 - Seven-bit reload, counts down, auto reload.
// R24 - Software clears write collision flag itself.
// R25 - Lines only pulled low or released.
package i2cm_pkg;

    // --------------------------------------------------------------
    // Field positions and widths
    // --------------------------------------------------------------
    localparam int RELOAD_W       = 7;
    localparam int RESTART_LOAD_W = 6;
    localparam int CTL2_WR_W      = 5;
    localparam int CTL2_START_BIT = 0;
    localparam int CTL2_RSTRT_BIT = 1;
    localparam int BYTE_W         = 8;
    localparam int BIT_IDX_W      = 4;

    // --------------------------------------------------------------
    // Byte sequencing and reset values
    // --------------------------------------------------------------
    localparam logic [BIT_IDX_W-1:0] LAST_DATA_IDX = 4'h7;
    localparam logic [BIT_IDX_W-1:0] ACK_IDX       = 4'h8;
    localparam logic [RELOAD_W-1:0]  CNT_RST       = 7'h00;
    localparam logic [BYTE_W-1:0]    SHIFT_RST     = 8'h00;

    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_S_CHK   = 4'h1,
        ST_S_HOLD  = 4'h3,
        ST_R_SCLLO = 4'h2,
        ST_R_SDARL = 4'h6,
        ST_R_SCLRL = 4'h7,
        ST_R_HIGH  = 4'h5,
        ST_R_SDALO = 4'h4,
        ST_T_LOW   = 4'hc,
        ST_T_RISE  = 4'hd,
        ST_T_HIGH  = 4'hf
    } i2cm_state_t;

endpackage

// File: src/i2cm_brg_if.sv
// Carrier between the sequencer and its reload counter.
`timescale 1ns/100ps
interface i2cm_brg_if;
    import i2cm_pkg::*;
    logic                load;
    logic                run;
    logic [RELOAD_W-1:0] value;
    logic                tick;
    logic [RELOAD_W-1:0] cnt;

    modport ctl (output load, output run, output value, input tick, input cnt);
    modport cnt_side (input load, input run, input value, output tick, output cnt);
endinterface

// File: src/i2cm_reload_counter.sv
// Reload counter that times every rollover of the serial clock.
`timescale 1ns/100ps
module i2cm_reload_counter
    import i2cm_pkg::*;
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   srst,
    // Sequencer side
    i2cm_brg_if.cnt_side brg
);

    logic [RELOAD_W-1:0] cnt_ff;

    // Counts down on every system clock while run is set; stops at zero until the sequencer reloads.
    always_ff @(posedge core_clk) begin // R02 R23
        if (srst) begin
            cnt_ff <= CNT_RST;
        end else if (brg.load) begin
            cnt_ff <= brg.value;
        end else if (brg.run && (cnt_ff != CNT_RST)) begin
            cnt_ff <= cnt_ff - 7'h01;
        end
    end

    assign brg.tick = brg.run && (cnt_ff == CNT_RST);
    assign brg.cnt  = cnt_ff;

endmodule

// File: src/i2cm_master_seq.sv
// Master sequencer: start, repeated start and byte transmit with clock arbitration.
`timescale 1ns/100ps
module i2cm_master_seq
    import i2cm_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // Reload value of this instance
    input  wire logic [RELOAD_W-1:0]  reload_value_register,
    // Control-two and transfer buffer writes
    input  wire logic                 ctl2_wr,
    input  wire logic [CTL2_WR_W-1:0] ctl2_wdata,
    input  wire logic                 txbuf_wr,
    input  wire logic [BYTE_W-1:0]    txbuf_wdata,
    // Software clears of sticky flags
    input  wire logic                 write_collision_flag_clr,
    input  wire logic                 sef_clr,
    input  wire logic                 bcl_clr,
    // Status
    output logic                      start_request_bit,
    output logic                      restart_request_bit,
    output logic                      ack_result_flag,
    output logic                      buffer_full_flag,
    output logic                      start_seen_flag,
    output logic                      write_collision_flag,
    output logic                      serial_event_flag,
    output logic                      collision_event_flag,
    // Bus lines
    input  wire logic                 scl_i,
    output logic                      scl_o,
    output logic                      scl_oe,
    input  wire logic                 sda_i,
    output logic                      sda_o,
    output logic                      sda_oe
);

    // --------------------------------------------------------------
    // Line samplers
    // --------------------------------------------------------------
    logic scl_meta_ff;
    logic scl_s_ff;
    logic sda_meta_ff;
    logic sda_s_ff;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_meta_ff <= 1'b1;
            scl_s_ff    <= 1'b1;
            sda_meta_ff <= 1'b1;
            sda_s_ff    <= 1'b1;
        end else begin
            scl_meta_ff <= scl_i;
            scl_s_ff    <= scl_meta_ff;
            sda_meta_ff <= sda_i;
            sda_s_ff    <= sda_meta_ff;
        end
    end

    // --------------------------------------------------------------
    // Reload counter
    // --------------------------------------------------------------
    i2cm_brg_if brg_if ();

    i2cm_reload_counter u_cnt (  // R01
        .core_clk (core_clk),
        .srst     (srst),
        .brg      (brg_if)
    );

    i2cm_state_t            state_ff;
    logic [BYTE_W-1:0]      shift_ff;
    logic [BIT_IDX_W-1:0]   bit_idx_ff;
    logic                   tick;
    logic                   idle;
    logic                   start_go;
    logic                   rs_go;
    logic                   tx_go;
    logic                   write_collision_flag_ev;
    logic                   coll;
    logic                   lines_high;
    logic                   byte_end;

    assign tick       = brg_if.tick;
    assign idle       = (state_ff == ST_IDLE);
    assign lines_high = scl_s_ff && sda_s_ff;
    assign byte_end   = (state_ff == ST_T_HIGH) && tick && (bit_idx_ff == ACK_IDX);
    // Only an idle sequencer accepts events; nothing is queued.
    assign start_go   = idle && ctl2_wr && ctl2_wdata[CTL2_START_BIT];                             // R10
    assign rs_go      = idle && ctl2_wr && !ctl2_wdata[CTL2_START_BIT] && ctl2_wdata[CTL2_RSTRT_BIT]; // R11
    assign tx_go      = idle && txbuf_wr && !(ctl2_wr && (ctl2_wdata[CTL2_START_BIT] || ctl2_wdata[CTL2_RSTRT_BIT]));
    assign write_collision_flag_ev    = txbuf_wr && !tx_go; // R09 R16

    // --------------------------------------------------------------
    // Collision detection
    // --------------------------------------------------------------
    always_comb begin
        coll = 1'b0;
        unique case (state_ff)
            ST_IDLE:    coll = start_go && !lines_high;              // R08
            ST_S_CHK:   coll = !scl_s_ff || (tick && !sda_s_ff);     // R08
            ST_R_SDARL: coll = tick && !sda_s_ff;                    // R15
            ST_R_SCLRL: coll = scl_s_ff && !sda_s_ff;                // R15
            ST_R_HIGH:  coll = !scl_s_ff;                            // R15
            default:    coll = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // Counter control
    // --------------------------------------------------------------
    always_comb begin
        brg_if.load  = 1'b0;
        brg_if.run   = 1'b0;
        brg_if.value = reload_value_register;
        unique case (state_ff)
            ST_IDLE:    brg_if.load = (start_go && !coll) || tx_go;  // R06 R18
            ST_S_CHK:   brg_if.load = tick && !coll;                 // R07
            ST_R_SCLLO: begin
                brg_if.load  = !scl_s_ff;                            // R12
                brg_if.value = {1'b0, reload_value_register[RESTART_LOAD_W-1:0]};
            end
            ST_R_SCLRL: brg_if.load = scl_s_ff && !coll;             // R05 R13
            ST_R_HIGH:  brg_if.load = tick && !coll;                 // R13
            ST_T_RISE:  brg_if.load = scl_s_ff;                      // R04 R05
            ST_T_HIGH:  brg_if.load = tick && (bit_idx_ff != ACK_IDX);
            default:    brg_if.load = 1'b0;
        endcase
        unique case (state_ff)
            ST_S_CHK, ST_S_HOLD, ST_R_SDARL, ST_R_HIGH, ST_R_SDALO, ST_T_LOW, ST_T_HIGH: brg_if.run = 1'b1;
            default:    brg_if.run = 1'b0;
        endcase
    end

    // --------------------------------------------------------------
    // Sequencer state
    // --------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst || coll) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (start_go) begin
                        state_ff <= ST_S_CHK;
                    end else if (rs_go) begin
                        state_ff <= ST_R_SCLLO;
                    end else if (tx_go) begin
                        state_ff <= ST_T_LOW;
                    end
                end
                ST_S_CHK:   if (tick) state_ff <= ST_S_HOLD;
                ST_S_HOLD:  if (tick) state_ff <= ST_IDLE;                   // R07
                ST_R_SCLLO: if (!scl_s_ff) state_ff <= ST_R_SDARL;
                ST_R_SDARL: if (tick) state_ff <= ST_R_SCLRL;
                ST_R_SCLRL: if (scl_s_ff) state_ff <= ST_R_HIGH;             // R04
                ST_R_HIGH:  if (tick) state_ff <= ST_R_SDALO;
                ST_R_SDALO: if (tick) state_ff <= ST_IDLE;                   // R13
                ST_T_LOW:   if (tick) state_ff <= ST_T_RISE;                 // R19
                ST_T_RISE:  if (scl_s_ff) state_ff <= ST_T_HIGH;             // R04
                ST_T_HIGH: begin
                    if (tick) begin
                        state_ff <= (bit_idx_ff == ACK_IDX) ? ST_IDLE : ST_T_LOW; // R22 R03
                    end
                end
                default:    state_ff <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Shifter and bit index
    // --------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            shift_ff   <= SHIFT_RST;
            bit_idx_ff <= 4'h0;
        end else if (tx_go) begin
            shift_ff   <= txbuf_wdata;                                       // R18
            bit_idx_ff <= 4'h0;
        end else if ((state_ff == ST_T_HIGH) && tick) begin
            shift_ff   <= {shift_ff[BYTE_W-2:0], 1'b0};
            bit_idx_ff <= bit_idx_ff + 4'h1;
        end
    end

    // --------------------------------------------------------------
    // Line drivers
    // --------------------------------------------------------------
    // The pads are open drain: a one only releases the line, so a stretching
    // device or a competing master always wins the wire.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_o  <= 1'b0;                                                  // R25
            sda_o  <= 1'b0;                                                  // R25
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (coll) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (rs_go) begin
                        scl_oe <= 1'b1;                                      // R12
                    end else if (tx_go) begin
                        scl_oe <= 1'b1;
                        sda_oe <= !txbuf_wdata[BYTE_W-1];                    // R19
                    end
                end
                ST_S_CHK:   if (tick) sda_oe <= 1'b1;                        // R06
                ST_R_SCLLO: if (!scl_s_ff) sda_oe <= 1'b0;                   // R12
                ST_R_SDARL: if (tick) scl_oe <= 1'b0;                        // R12
                ST_R_HIGH:  if (tick) sda_oe <= 1'b1;                        // R13
                ST_T_LOW:   if (tick) scl_oe <= 1'b0;                        // R19
                ST_T_HIGH: begin
                    if (tick) begin
                        scl_oe <= 1'b1;                                      // R19 R22
                        if (bit_idx_ff < LAST_DATA_IDX) begin
                            sda_oe <= !shift_ff[BYTE_W-2];                   // R19
                        end else if (bit_idx_ff == LAST_DATA_IDX) begin
                            sda_oe <= 1'b0;                                  // R20
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Request bits and status flags
    // --------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst || coll) begin
            start_request_bit   <= 1'b0;                                     // R08
            restart_request_bit <= 1'b0;
        end else begin
            if (start_go) begin
                start_request_bit <= 1'b1;
            end else if ((state_ff == ST_S_HOLD) && tick) begin
                start_request_bit <= 1'b0;                                   // R07
            end
            if (rs_go) begin
                restart_request_bit <= 1'b1;
            end else if ((state_ff == ST_R_SDALO) && tick) begin
                restart_request_bit <= 1'b0;                                 // R13
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            start_seen_flag <= 1'b0;
        end else if (((state_ff == ST_S_CHK) || (state_ff == ST_R_HIGH)) && tick && !coll) begin
            start_seen_flag <= 1'b1;                                         // R06 R14
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst || coll) begin
            buffer_full_flag <= 1'b0;
        end else if (tx_go) begin
            buffer_full_flag <= 1'b1;                                        // R18
        end else if ((state_ff == ST_T_HIGH) && tick && (bit_idx_ff == LAST_DATA_IDX)) begin
            buffer_full_flag <= 1'b0;                                        // R20
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            ack_result_flag <= 1'b0;
        end else if (byte_end) begin
            ack_result_flag <= sda_s_ff;                                     // R21
        end
    end

    // Sticky flags: a hardware set in the clear cycle wins.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_event_flag    <= 1'b0;
            write_collision_flag <= 1'b0;
            collision_event_flag <= 1'b0;
        end else begin
            if ((((state_ff == ST_S_HOLD) || (state_ff == ST_R_SDALO)) && tick) || byte_end) begin
                serial_event_flag <= 1'b1;                                   // R14 R22
            end else if (sef_clr) begin
                serial_event_flag <= 1'b0;
            end
            if (write_collision_flag_ev) begin
                write_collision_flag <= 1'b1;                                // R09 R16
            end else if (write_collision_flag_clr) begin
                write_collision_flag <= 1'b0;                                // R24
            end
            if (coll) begin
                collision_event_flag <= 1'b1;                                // R08 R15
            end else if (bcl_clr) begin
                collision_event_flag <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    AST_PULL_ONLY: assert property (!scl_o && !sda_o) // R25
        else $error("Line driven high.");
    AST_START_DRIVE: assert property ((state_ff == ST_S_CHK) && tick && lines_high |=> sda_oe && start_seen_flag) // R06
        else $error("Start did not pull data low.");
    AST_START_DONE: assert property ((state_ff == ST_S_HOLD) && tick |=> !start_request_bit && sda_oe && idle) // R07
        else $error("Start did not complete.");
    AST_START_COLL: assert property (start_go && !lines_high |=> collision_event_flag && idle) // R08
        else $error("Start collision missed.");
    AST_WRITE_COLLISION_FLAG_START: assert property (txbuf_wr && (state_ff inside {ST_S_CHK, ST_R_HIGH}) && !tick |=> write_collision_flag && $stable(shift_ff) && !buffer_full_flag) // R09
        else $error("Buffer write during start not refused.");
    AST_CTL2_IGNORED: assert property (ctl2_wr && !idle && !start_request_bit |=> !start_request_bit) // R10
        else $error("Control write taken while busy.");
    AST_STRETCH_PAUSE: assert property ((state_ff == ST_T_RISE) && !scl_s_ff |=> $stable(brg_if.cnt) && (state_ff == ST_T_RISE)) // R04
        else $error("Counter ran while clock held low.");
    AST_HIGH_RELOAD: assert property ((state_ff == ST_T_RISE) && scl_s_ff |=> brg_if.cnt == $past(reload_value_register)) // R05
        else $error("No reload when clock seen high.");
    AST_RS_LOAD: assert property ((state_ff == ST_R_SCLLO) && !scl_s_ff |=> !sda_oe && scl_oe
        && (brg_if.cnt == {1'b0, $past(reload_value_register[RESTART_LOAD_W-1:0])})) // R12
        else $error("Restart short load wrong.");
    AST_BF_CLEAR: assert property ((state_ff == ST_T_HIGH) && tick && (bit_idx_ff == LAST_DATA_IDX) |=> !buffer_full_flag && !sda_oe) // R20
        else $error("Full flag or data not released after eighth bit.");
    AST_ACK_END: assert property (byte_end |=> (ack_result_flag == $past(sda_s_ff)) && serial_event_flag && scl_oe && idle) // R21
        else $error("Acknowledge end of byte wrong.");

    COV_START: cover property ((state_ff == ST_S_HOLD) && tick);
    COV_RESTART: cover property ((state_ff == ST_R_SDALO) && tick);
    COV_BYTE: cover property (byte_end);
    COV_COLL: cover property (coll);

endmodule

// File: test/i2cm_slave_model.sv
// Behavioural slave on the two-wire bus: takes bytes, acknowledges and stretches the clock.
`timescale 1ns/100ps
module i2cm_slave_model (
    // Bus line levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Pull-downs onto the lines
    output logic            scl_pull,
    output logic            sda_pull,
    // Bench controls
    input  wire logic       ack_en,
    input  wire logic [3:0] stretch,
    input  wire logic       hold_sda,
    // Observed traffic
    output logic [7:0]      rx_byte,
    output int              starts
);
    logic [7:0] shift_ff;
    logic       ack_pull;
    int         rises;

    // The model only ever pulls low; the pull-up gives the high level.
    assign sda_pull = ack_pull | hold_sda;

    initial begin
        scl_pull = 1'b0;
        ack_pull = 1'b0;
        shift_ff = 8'h00;
        rx_byte  = 8'h00;
        rises    = 0;
        starts   = 0;
    end

    // A falling data line while the clock is high marks a start or repeated start.
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            rises = 0;
            starts++;
        end
    end

    // Data is taken on the rising clock edge, most significant bit first.
    always @(posedge scl) begin
        if (rises < 8) begin
            shift_ff = {shift_ff[6:0], sda};
        end
        rises++;
    end

    // The acknowledge is held through the ninth bit; the low phase may be stretched.
    always @(negedge scl) begin
        if (rises == 8) begin
            rx_byte  = shift_ff;
            ack_pull = ack_en;
        end else if (rises == 9) begin
            #23 ack_pull = 1'b0;
            rises = 0;
        end
        if (stretch != 4'h0) begin
            scl_pull = 1'b1;
            // The odd offset keeps the release away from the system clock edges.
            #(int'(stretch) * 100 + 3) scl_pull = 1'b0;
        end
    end
endmodule

// File: test/i2cm_master_seq_tb.sv
// Self-checking bench of the two-wire master sequencer against a behavioural slave.
`timescale 1ns/100ps
module i2cm_master_seq_tb;
    import i2cm_pkg::*;
    logic                 core_clk, srst, ctl2_wr, txbuf_wr, write_collision_flag_clr, sef_clr, bcl_clr, scl_i, sda_i;
    logic [RELOAD_W-1:0]  reload_value_register;
    logic [CTL2_WR_W-1:0] ctl2_wdata;
    logic [BYTE_W-1:0]    txbuf_wdata, byte_v, rx_byte;
    logic                 start_request_bit, restart_request_bit, ack_result_flag, buffer_full_flag;
    logic                 start_seen_flag, write_collision_flag, serial_event_flag, collision_event_flag;
    logic                 scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda, ack_en, hold_sda;
    logic [3:0]           stretch;
    int                   num_errors, samples_checked, cycles, seed, starts, hi_cnt, hi_min, n, i;

    i2cm_master_seq u_i2cm_master_seq (.core_clk, .srst, .reload_value_register, .ctl2_wr, .ctl2_wdata,
        .txbuf_wr, .txbuf_wdata, .write_collision_flag_clr, .sef_clr, .bcl_clr, .start_request_bit, .restart_request_bit,
        .ack_result_flag, .buffer_full_flag, .start_seen_flag, .write_collision_flag, .serial_event_flag,
        .collision_event_flag, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
    i2cm_slave_model u_i2cm_slave_model (.scl(scl_i), .sda(sda_i), .scl_pull(s_scl), .sda_pull(s_sda),
        .ack_en, .stretch, .hold_sda, .rx_byte, .starts);

    // Wired-AND lines with pull-ups.
    assign scl_i = (scl_oe ? scl_o : 1'b1) & ~s_scl;
    assign sda_i = (sda_oe ? sda_o : 1'b1) & ~s_sda;

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Shortest clock-high phase seen, and the hang guard.
    always @(posedge core_clk) begin
        cycles++;
        if (scl_i) begin
            hi_cnt++;
        end else begin
            if (hi_cnt != 0 && hi_cnt < hi_min) hi_min = hi_cnt;
            hi_cnt = 0;
        end
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobe: 0 control-two, 1 buffer, 2 write_collision_flag clear, 3 event clear, 4 collision clear.
    task automatic strobe(input int which, input logic [7:0] d);
        ctl2_wdata = d[4:0];
        txbuf_wdata = d;
        {bcl_clr, sef_clr, write_collision_flag_clr, txbuf_wr, ctl2_wr} = 5'(1 << which);
        @(negedge core_clk);
        {bcl_clr, sef_clr, write_collision_flag_clr, txbuf_wr, ctl2_wr} = 5'h00;
        // A quiet cycle keeps back-to-back strobes from changing twice in one step.
        @(negedge core_clk);
    endtask

    task automatic wait_sef();
        int k;
        k = 0;
        while (serial_event_flag !== 1'b1 && collision_event_flag !== 1'b1 && k < 3000) begin
            @(negedge core_clk);
            k++;
        end
        check(8'(k < 3000), 8'h01);
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        seed = 32'he0b5;
        {srst, ack_en, hold_sda} = 3'b110;
        stretch = 4'h0;
        {bcl_clr, sef_clr, write_collision_flag_clr, txbuf_wr, ctl2_wr} = 5'h00;
        ctl2_wdata = 5'h00;
        txbuf_wdata = 8'h00;
        num_errors = 0;
        samples_checked = 0;
        cycles = 0;
        hi_cnt = 0;
        hi_min = 999;
        reload_value_register = 7'(4 + ($random(seed) & 3));
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        check({start_request_bit, restart_request_bit, ack_result_flag, buffer_full_flag, start_seen_flag,
               write_collision_flag, serial_event_flag, collision_event_flag}, 8'h00);
        check(8'({scl_o, scl_oe, sda_o, sda_oe}), 8'h00);
        // Start, with a buffer write and a restart request refused while it runs.
        strobe(0, 8'h01);
        strobe(1, 8'ha5);
        strobe(0, 8'h02);
        check(8'({write_collision_flag, restart_request_bit}), 8'h02);
        while (sda_oe !== 1'b1 && cycles < 19000) @(negedge core_clk);
        check(8'(start_seen_flag), 8'h01);
        n = 0;
        while (start_request_bit === 1'b1 && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        check(8'(n), 8'(reload_value_register + 1));
        wait_sef();
        check(8'({serial_event_flag, sda_oe, scl_oe, 5'(starts)}), 8'hc1);
        strobe(2, 8'h00);
        strobe(3, 8'h00);
        check(8'({write_collision_flag, serial_event_flag}), 8'h00);
        // Bytes: corner values and random ones, with a refusal and stretching.
        for (i = 0; i < 6; i++) begin
            byte_v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            ack_en = (i != 2);
            stretch = (i % 2 == 1) ? 4'(1 + ($random(seed) & 1)) : 4'h0;
            hi_min = 999;
            if (i == 5) begin
                strobe(0, 8'h02);
                check(8'(restart_request_bit), 8'h01);
                strobe(1, 8'h5a);
                check(8'({write_collision_flag, buffer_full_flag}), 8'h02);
                strobe(2, 8'h00);
                wait_sef();
                check(8'({restart_request_bit, sda_oe, start_seen_flag, 5'(starts)}), 8'h62);
                strobe(3, 8'h00);
            end
            strobe(1, byte_v);
            @(negedge core_clk);
            check(8'({buffer_full_flag, scl_oe}), 8'h03);
            if (i == 3) begin
                strobe(0, 8'h01);
                check(8'(start_request_bit), 8'h00);
            end
            wait_sef();
            check(rx_byte, byte_v);
            check(8'({ack_result_flag, buffer_full_flag}), 8'({~ack_en, 1'b0}));
            check(8'(hi_min >= reload_value_register + 1), 8'h01);
            repeat (20) @(negedge core_clk);
            check(8'({serial_event_flag, scl_oe, scl_i}), 8'h06);
            strobe(3, 8'h00);
        end
        // Restart while another device holds the data line low.
        stretch = 4'h0;
        hold_sda = 1'b1;
        strobe(0, 8'h02);
        wait_sef();
        check(8'({collision_event_flag, restart_request_bit, scl_oe, sda_oe}), 8'h08);
        // Second reset, then a start with the data line already low.
        srst = 1'b1;
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        check(8'({collision_event_flag, start_request_bit}), 8'h00);
        strobe(0, 8'h01);
        @(negedge core_clk);
        check(8'({collision_event_flag, start_request_bit, sda_oe}), 8'h04);
        strobe(4, 8'h00);
        check(8'(collision_event_flag), 8'h00);
        report_and_stop();
    end
endmodule
